// >>> shared/mbfield_pkg.sv
// Constants and carrier types for the multi-byte field update block.
// Assumes a byte-wide register write strobe from the serial port logic.
package mbfield_pkg;

  // ----------------------------------------------------------------------
  // Address layout
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W       = 16;
  localparam int unsigned BYTE_W       = 8;
  // Repeated block: instance 0 at base, next at base + stride
  localparam logic [15:0] BLK_BASE     = 16'h0010;
  localparam logic [15:0] BLK_STRIDE   = 16'h0008;
  localparam int unsigned BLK_COUNT    = 2;
  // Field offsets within one block instance
  localparam logic [15:0] ATOM_OFS     = 16'h0000;
  localparam int unsigned ATOM_BYTES   = 4;
  localparam logic [15:0] PLAIN_OFS    = 16'h0004;
  localparam int unsigned PLAIN_BYTES  = 2;
  // Stand-alone half-word field
  localparam logic [15:0] HWORD_ADDR   = 16'h0042;
  localparam int unsigned HWORD_BYTES  = 2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] ATOM_RST     = 32'h0000_0000;
  localparam logic [15:0] PLAIN_RST    = 16'h0000;
  localparam logic [15:0] HWORD_RST    = 16'h0000;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } byte_write_t;

  typedef struct packed {
    logic [31:0] atom_value;
    logic [15:0] plain_value;
  } block_fields_t;

endpackage

// >>> rtl/multibyte_field_update.sv
// Multi-byte register field layout and update timing.
// Assumes the serial port hands over one byte write per strobe.
// Operation
// - Least significant byte at field base; higher bytes at rising addresses.
// - Bit 0 is the least significant bit, width minus one the most.
// - Atomic field lower-byte writes are shadowed, not applied.
// - Writing atomic top byte applies the whole field in one update.
// - Non-atomic field bytes apply immediately and independently.
// - Block instance n decodes at base plus n times stride.
`timescale 1ns/1ps
`default_nettype none

module multibyte_field_update #(
  parameter int unsigned NUM_BLK = mbfield_pkg::BLK_COUNT
) (
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  input  wire mbfield_pkg::byte_write_t   wr_in,
  output var  mbfield_pkg::block_fields_t blk_fields [NUM_BLK],
  output logic [15:0]                     hword_value,
  output logic [NUM_BLK-1:0]              atom_update
);

  // ----------------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------------
  // Base of instance n; stride product kept to address width
  function automatic logic [15:0] inst_base(input int unsigned n);
    logic [31:0] prod;
    prod = 32'(n) * 32'(mbfield_pkg::BLK_STRIDE);
    return mbfield_pkg::BLK_BASE + prod[15:0];
  endfunction

  // Byte lane of addr within a field, or an out-of-range marker
  function automatic int lane_of(input logic [15:0] addr,
                                 input logic [15:0] base,
                                 input int unsigned nbytes);
    logic [15:0] diff;
    diff = addr - base;
    if (addr >= base && 32'(diff) < nbytes) begin
      return int'(diff);
    end
    return -1;
  endfunction

  // Value with one byte lane replaced by data
  function automatic logic [31:0] with_byte(input logic [31:0] value,
                                            input logic [1:0]  lane,
                                            input logic [7:0]  data);
    logic [31:0] res;
    res = value;
    res[lane*8 +: 8] = data;
    return res;
  endfunction

  // Lane of the atomic field's most significant byte
  localparam int ATOM_TOP = int'(mbfield_pkg::ATOM_BYTES) - 1;

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  // Decoded once, so every state group sees the same lane and hit
  logic [NUM_BLK-1:0] atom_hit;
  logic [NUM_BLK-1:0] atom_top;
  logic [1:0]         atom_lane  [NUM_BLK];
  logic [NUM_BLK-1:0] plain_hit;
  logic [1:0]         plain_lane [NUM_BLK];
  logic               hword_hit;
  logic [1:0]         hword_lane;

  always_comb begin
    int ln;
    ln = -1;
    atom_hit = '0;
    atom_top = '0;
    plain_hit = '0;
    hword_hit = 1'b0;
    hword_lane = 2'b00;
    for (int i = 0; i < NUM_BLK; i++) begin
      atom_lane[i] = 2'b00;
      plain_lane[i] = 2'b00;
    end
    if (wr_in.valid) begin
      for (int i = 0; i < NUM_BLK; i++) begin
        ln = lane_of(wr_in.addr,
                     inst_base(i) + mbfield_pkg::ATOM_OFS,
                     mbfield_pkg::ATOM_BYTES);
        if (ln >= 0) begin
          atom_hit[i] = 1'b1;
          atom_lane[i] = 2'(ln);
          atom_top[i] = (ln == ATOM_TOP);
        end
        ln = lane_of(wr_in.addr,
                     inst_base(i) + mbfield_pkg::PLAIN_OFS,
                     mbfield_pkg::PLAIN_BYTES);
        if (ln >= 0) begin
          plain_hit[i] = 1'b1;
          plain_lane[i] = 2'(ln);
        end
      end
      ln = lane_of(wr_in.addr, mbfield_pkg::HWORD_ADDR,
                   mbfield_pkg::HWORD_BYTES);
      if (ln >= 0) begin
        hword_hit = 1'b1;
        hword_lane = 2'(ln);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Atomic field: shadow buffer, applied value, update pulse
  // ----------------------------------------------------------------------
  // Shadow is not cleared on update: a lone top-byte write reapplies the
  // lower bytes last held, which saves a written flag per lane
  logic [31:0]        shadow_reg  [NUM_BLK];
  logic [31:0]        shadow_next [NUM_BLK];
  logic [31:0]        atom_reg    [NUM_BLK];
  logic [31:0]        atom_next   [NUM_BLK];
  logic [NUM_BLK-1:0] upd_reg;
  logic [NUM_BLK-1:0] upd_next;

  always_comb begin
    logic [31:0] merged;
    merged = '0;
    upd_next = '0;
    for (int i = 0; i < NUM_BLK; i++) begin
      shadow_next[i] = shadow_reg[i];
      atom_next[i] = atom_reg[i];
      if (atom_hit[i]) begin
        merged = with_byte(shadow_reg[i], atom_lane[i], wr_in.data);
        shadow_next[i] = merged;
        if (atom_top[i]) begin
          atom_next[i] = merged;
          upd_next[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_BLK; i++) begin
        shadow_reg[i] <= mbfield_pkg::ATOM_RST;
        atom_reg[i] <= mbfield_pkg::ATOM_RST;
      end
      upd_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_BLK; i++) begin
        shadow_reg[i] <= shadow_next[i];
        atom_reg[i] <= atom_next[i];
      end
      upd_reg <= upd_next;
    end
  end

  // ----------------------------------------------------------------------
  // Plain field: every byte applies at once
  // ----------------------------------------------------------------------
  logic [15:0] plain_reg  [NUM_BLK];
  logic [15:0] plain_next [NUM_BLK];

  always_comb begin
    logic [31:0] widened;
    widened = '0;
    for (int i = 0; i < NUM_BLK; i++) begin
      plain_next[i] = plain_reg[i];
      if (plain_hit[i]) begin
        widened = with_byte({16'h0000, plain_reg[i]}, plain_lane[i],
                            wr_in.data);
        plain_next[i] = widened[15:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_BLK; i++) begin
        plain_reg[i] <= mbfield_pkg::PLAIN_RST;
      end
    end else begin
      for (int i = 0; i < NUM_BLK; i++) begin
        plain_reg[i] <= plain_next[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Stand-alone half-word field
  // ----------------------------------------------------------------------
  logic [15:0] hword_reg;
  logic [15:0] hword_next;

  always_comb begin
    logic [31:0] widened;
    widened = '0;
    hword_next = hword_reg;
    if (hword_hit) begin
      widened = with_byte({16'h0000, hword_reg}, hword_lane, wr_in.data);
      hword_next = widened[15:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      hword_reg <= mbfield_pkg::HWORD_RST;
    end else begin
      hword_reg <= hword_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_BLK; i++) begin
      blk_fields[i].atom_value = atom_reg[i];
      blk_fields[i].plain_value = plain_reg[i];
    end
  end

  assign hword_value = hword_reg;
  assign atom_update = upd_reg;

endmodule

`default_nettype wire

// >>> test/mbfield_chk.sv
// Assertions on the multi-byte field update ports.
// Assumes a bind from the bench top and one byte write per cycle.
`timescale 1ns/1ps
`default_nettype none
module mbfield_chk #(parameter int unsigned NUM_BLK = 2) (
  input wire logic                       clk_sys,
  input wire logic                       resetn,
  input wire mbfield_pkg::byte_write_t   wr_in,
  input wire mbfield_pkg::block_fields_t blk_fields [NUM_BLK],
  input wire logic [15:0]                hword_value,
  input wire logic [NUM_BLK-1:0]         atom_update
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic [15:0] a = wr_in.addr;
  wire logic        v = wr_in.valid;
  chk_hword_low: assert property (v && a == 16'h0042 |=>
    hword_value[7:0] == $past(wr_in.data)) else $error("hword low byte");
  chk_hword_high: assert property (v && a == 16'h0043 |=>
    hword_value[15:8] == $past(wr_in.data)) else $error("hword high byte");
  chk_shadow_hold: assert property (v && a == 16'h0010 |=>
    $stable(blk_fields[0].atom_value) && !atom_update[0])
    else $error("lower byte leaked");
  chk_atom_apply: assert property (v && a == 16'h0013 |=>
    atom_update[0]
    && blk_fields[0].atom_value[31:24] == $past(wr_in.data))
    else $error("atomic apply");
  chk_pulse_cause: assert property (atom_update[0] |->
    $past(v && a == 16'h0013)) else $error("update without top byte");
  chk_plain_now: assert property (v && a == 16'h0014 |=>
    blk_fields[0].plain_value[7:0] == $past(wr_in.data)) else $error("plain");
  chk_stride_decode: assert property (v && a == 16'h001B |=>
    atom_update[1] && !atom_update[0]) else $error("instance decode");
  cover property (atom_update[0]);
  cover property (atom_update[1]);
  cover property (v && a == 16'h0043);
endmodule
`default_nettype wire

// >>> test/host_writer.sv
// Host model issuing byte writes to the field block.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps
`default_nettype none
module host_writer (
  input  wire logic                clk_sys,
  output var mbfield_pkg::byte_write_t wr_out
);
  initial wr_out = '0;
  task automatic put(input logic [15:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    #1 wr_out = '{1'b1, addr, data};
  endtask
  // Released lines show the inverse of the previous values; a second idle in a row restores them
  task automatic idle();
    @(posedge clk_sys);
    #1 wr_out = '{1'b0, ~wr_out.addr, ~wr_out.data};
  endtask
endmodule
`default_nettype wire

// >>> test/multibyte_field_update_tb_top.sv
// Self-checking bench for the multi-byte field update block.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module multibyte_field_update_tb_top;
  typedef struct {logic [15:0] a; logic [7:0] d; int s; logic [15:0] e;} row_t;
  logic                       clk_sys;
  logic                       resetn;
  mbfield_pkg::byte_write_t   wr_in;
  mbfield_pkg::block_fields_t blk_fields [2];
  logic [15:0]                hword_value;
  logic [1:0]                 atom_update;
  int                         fail_count = 0;
  int                         checks = 0;
  row_t rows [5] = '{'{16'h0042, 8'h5A, 0, 16'h005A},
    '{16'h0043, 8'hC3, 0, 16'hC35A}, '{16'h0014, 8'h11, 1, 16'h0011},
    '{16'h0015, 8'h22, 1, 16'h2211}, '{16'h001D, 8'h7E, 2, 16'h7E00}};
  host_writer host_writer_inst (.clk_sys(clk_sys), .wr_out(wr_in));
  multibyte_field_update #(.NUM_BLK(2)) multibyte_field_update_inst (
    .clk_sys(clk_sys), .resetn(resetn), .wr_in(wr_in),
    .blk_fields(blk_fields), .hword_value(hword_value),
    .atom_update(atom_update));
  function automatic logic [15:0] pick(input int s);
    return s == 0 ? hword_value : blk_fields[s-1].plain_value;
  endfunction
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #20000;
    fail_count++;
    test_done();
  end
  initial begin
    resetn = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 resetn = 1'b1;
    `CHK({atom_update, blk_fields[0].atom_value}, 34'h0)
    foreach (rows[i]) begin
      host_writer_inst.put(rows[i].a, rows[i].d);
      host_writer_inst.idle();
      `CHK(pick(rows[i].s), rows[i].e)
    end
    host_writer_inst.put(16'h0010, 8'hAA);
    host_writer_inst.put(16'h0011, 8'hBB);
    host_writer_inst.put(16'h0012, 8'hCC);
    host_writer_inst.put(16'h0030, 8'h99);
    `CHK(blk_fields[0].atom_value, 32'h0000_0000)
    host_writer_inst.put(16'h0013, 8'hDD);
    host_writer_inst.idle();
    `CHK(atom_update, 2'b01)
    `CHK(blk_fields[0].atom_value, 32'hDDCC_BBAA)
    host_writer_inst.put(16'h0011, 8'hEE);
    `CHK(atom_update, 2'b00)
    host_writer_inst.put(16'h0013, 8'h01);
    host_writer_inst.put(16'h001B, 8'h5C);
    `CHK(blk_fields[0].atom_value, 32'h01CC_EEAA)
    host_writer_inst.idle();
    `CHK(atom_update, 2'b10)
    `CHK(blk_fields[1].atom_value, 32'h5C00_0000)
    `CHK(hword_value, 16'hC35A)
    @(posedge clk_sys);
    #1 resetn = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 resetn = 1'b1;
    `CHK({atom_update, hword_value, blk_fields[1].plain_value}, 34'h0)
    `CHK(blk_fields[1].atom_value, 32'h0000_0000)
    host_writer_inst.put(16'h0013, 8'h42);
    host_writer_inst.idle();
    `CHK(blk_fields[0].atom_value, 32'h4200_0000)
    test_done();
  end
endmodule
bind multibyte_field_update mbfield_chk #(.NUM_BLK(NUM_BLK)) mbfield_chk_inst (
  .clk_sys(clk_sys), .resetn(resetn), .wr_in(wr_in),
  .blk_fields(blk_fields), .hword_value(hword_value),
  .atom_update(atom_update));
`default_nettype wire
